//--- rtl/rcc_pkg.sv
// Constants, bit layout and the cause enumeration shared by the reset cause tracker.
// Assumes a single 10 MHz clock; all times below convert to cycles of it.
// Functional notes
// [RULE1] Eight reset sources: power-on, pin (run and power-managed), watchdog, brown-out, instruction, stack.
// [RULE2] Low five control bits are event flags; together they show the last reset kind.
// [RULE3] Bit 7 turns on interrupt priority levels; cleared by every reset.
// [RULE4] Bit 6 is software brown-out enable only when field is 01, else reads 0.
// [RULE5] Software brown-out enable resets to 1 when config bits [2:1] are 01.
// [RULE6] Bit 5 is unimplemented and reads 0.
// [RULE7] Instruction flag bit 4 cleared by reset instruction, set on power-on; firmware re-sets it.
// [RULE8] Watchdog flag bit 3 set by power-up, clear or sleep; cleared by watchdog timeout.
// [RULE9] Power-down flag bit 2 set by power-up or watchdog clear; cleared by sleep.
// [RULE10] Power-on flag bit 1 cleared by power-on reset only; only software sets it.
// [RULE11] Brown-out flag bit 0 cleared by brown-out reset; only firmware sets it.
// [RULE12] Firmware reads brown-out 0 with power-on 1 as a brown-out indication.
// [RULE13] Firmware should set power-on flag after detecting a power-on reset.
// [RULE14] Reset values differ between power-on/brown-out and other resets; flags 3,2 read-only.
// [RULE15] Pin held low resets the device; short low pulses are filtered out.
// [RULE16] Weak pull-up on the pin whenever it serves as reset input.
// [RULE17] The pin is never driven low by any internal reset.
// [RULE18] With pin reset disabled, pin is a plain digital input, no reset source.
// [RULE19] Rising supply-good makes an internal power-on reset pulse.
// [RULE20] Brown-out field: 00 off, 01 software, 10 on except sleep, 11 always on.
// [RULE21] Internal reset held while any source is active; flags updated as a source asserts.
package rcc_pkg;
	localparam int CLK_PERIOD_NS = 100;
	localparam int PIN_FILTER_NS = 2000;
	localparam int PIN_FILTER_CYCLES = (PIN_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int INT_RESET_HOLD_NS = 1000;
	localparam int INT_RESET_HOLD_CYCLES = (INT_RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 5;

	localparam logic [1:0] REG_CTRL_ADDR = 2'h0;
	localparam logic [1:0] REG_CAUSE_ADDR = 2'h1;

	localparam int BIT_PRIO_LEVELS = 7;
	localparam int BIT_SOFT_BOD = 6;
	localparam int BIT_INSTR_N = 4;
	localparam int BIT_WDOG_N = 3;
	localparam int BIT_PWRDN_N = 2;
	localparam int BIT_POR = 1;
	localparam int BIT_BROWN_N = 0;

	localparam int CFG_BOD_FIELD_LSB = 1;
	localparam logic [1:0] BOD_FIELD_OFF = 2'h0;
	localparam logic [1:0] BOD_FIELD_SOFT = 2'h1;
	localparam logic [1:0] BOD_FIELD_NOSLEEP = 2'h2;
	localparam logic [1:0] BOD_FIELD_ALWAYS = 2'h3;

	localparam logic RST_PRIO_LEVELS = 1'h0;
	localparam logic RST_INSTR_N = 1'h1;
	localparam logic RST_WDOG_N = 1'h1;
	localparam logic RST_PWRDN_N = 1'h1;
	localparam logic RST_POR = 1'h0;
	localparam logic RST_BROWN_N = 1'h0;

	typedef enum logic [3:0] {
		CAUSE_NONE,
		CAUSE_POWER_ON,
		CAUSE_PIN_RUN,
		CAUSE_PIN_PM,
		CAUSE_WATCHDOG,
		CAUSE_BROWNOUT,
		CAUSE_INSTR,
		CAUSE_STACK_FULL,
		CAUSE_STACK_UNDER
	} rcc_cause_t;

	function automatic logic [CNT_W-1:0] rcc_sat_inc(input logic [CNT_W-1:0] v);
		rcc_sat_inc = (v == {CNT_W{1'b1}}) ? v : v + 1'b1;
	endfunction : rcc_sat_inc
endpackage : rcc_pkg

//--- rtl/rcc_stretch_if.sv
// Carries the internal reset request and its stretched result between the tracker and the stretcher.
// Assumes both ends sit in the ref_clk domain.
`timescale 1ns/1ps
interface rcc_stretch_if;
	logic load;
	logic active;
	modport requester (output load, input active);
	modport stretcher (input load, output active);
endinterface : rcc_stretch_if

//--- rtl/rcc_pin_filter.sv
// Noise filter for the active-low external reset pin.
// Assumes the pin input is already synchronous to ref_clk.
`timescale 1ns/1ps
module rcc_pin_filter
	import rcc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic enable,
	input wire logic pin_n,
	output logic reset_req
);
	logic [CNT_W-1:0] low_cnt;
	logic [CNT_W-1:0] next_low_cnt;
	logic next_reset_req;

	// a low shorter than the filter time never reaches the reset path
	always_comb begin
		next_low_cnt = low_cnt;
		next_reset_req = reset_req;
		if (!enable || pin_n) begin
			next_low_cnt = '0;
			next_reset_req = 1'b0;
		end else begin
			next_low_cnt = rcc_sat_inc(low_cnt);
			if (low_cnt >= CNT_W'(PIN_FILTER_CYCLES - 1)) begin // [RULE15]
				next_reset_req = 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			low_cnt <= '0;
			reset_req <= 1'b0;
		end else begin
			low_cnt <= next_low_cnt;
			reset_req <= next_reset_req;
		end
	end
endmodule : rcc_pin_filter

//--- rtl/rcc_reset_stretch.sv
// Stretches one-cycle reset requests into a fixed-length internal reset.
// Assumes requests are single-cycle pulses in the ref_clk domain.
`timescale 1ns/1ps
module rcc_reset_stretch
	import rcc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic srst,
	rcc_stretch_if.stretcher req
);
	logic [CNT_W-1:0] hold_cnt;
	logic [CNT_W-1:0] next_hold_cnt;

	// a new request restarts the full hold time
	always_comb begin
		next_hold_cnt = hold_cnt;
		if (req.load) begin
			next_hold_cnt = CNT_W'(INT_RESET_HOLD_CYCLES);
		end else if (hold_cnt != '0) begin
			next_hold_cnt = hold_cnt - 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			hold_cnt <= '0;
		end else begin
			hold_cnt <= next_hold_cnt;
		end
	end

	assign req.active = (hold_cnt != '0);
endmodule : rcc_reset_stretch

//--- rtl/rcc_reset_cause.sv
// Reset cause tracker: control/status flags, brown-out enable, pin handling, internal reset.
// Assumes detector outputs and core event pulses are synchronous to ref_clk.
//
// Decided for this implementation: the address-and-strobe port and the address map.
`timescale 1ns/1ps
module rcc_reset_cause (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic [1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic [7:0] config_word_low2,
	input wire logic ext_reset_pin_enable,
	input wire logic ext_reset_pin_n_in,
	output logic ext_reset_pin_n_out,
	output logic ext_reset_pin_n_oe_n,
	output logic ext_reset_pin_pullup_en,
	output logic pin_digital_in,
	input wire logic supply_good,
	input wire logic brownout_trip,
	input wire logic core_sleeping,
	input wire logic core_power_managed,
	input wire logic watchdog_timeout,
	input wire logic watchdog_clear_instr,
	input wire logic sleep_instr,
	input wire logic reset_instr,
	input wire logic stack_full,
	input wire logic stack_underflow,
	output logic sys_reset,
	output logic brownout_detect_enable,
	output logic irq_priority_levels_on,
	output rcc_pkg::rcc_cause_t last_cause
);
	import rcc_pkg::*;

	logic soft_brownout_enable;
	logic reset_instr_flag_n;
	logic watchdog_timeout_flag_n;
	logic powerdown_flag_n;
	logic poweron_flag_n;
	logic brownout_flag_n;
	logic next_irq_priority_levels_on;
	logic next_soft_brownout_enable;
	logic next_reset_instr_flag_n;
	logic next_watchdog_timeout_flag_n;
	logic next_powerdown_flag_n;
	logic next_poweron_flag_n;
	logic next_brownout_flag_n;
	rcc_cause_t next_last_cause;
	logic [7:0] next_reg_rdata;
	logic supply_good_q;
	logic brownout_q;
	logic pin_reset_q;
	logic pin_sample;
	logic next_supply_good_q;
	logic next_brownout_q;
	logic next_pin_reset_q;
	logic next_pin_sample;
	logic [1:0] brownout_config_field;
	logic soft_mode;
	logic brownout_active;
	logic pin_reset;
	logic por_evt;
	logic bor_evt;
	logic pin_evt;
	logic wdt_evt;
	logic instr_evt;
	logic stkf_evt;
	logic stku_evt;
	logic any_reset_evt;
	logic ctrl_wr;
	logic [7:0] ctrl_view;

	rcc_stretch_if stretch_bus ();

	assign brownout_config_field = config_word_low2[CFG_BOD_FIELD_LSB +: 2];
	assign soft_mode = (brownout_config_field == BOD_FIELD_SOFT);

	// brown-out detector gating by configuration field
	always_comb begin
		unique case (brownout_config_field)
			BOD_FIELD_OFF: brownout_detect_enable = 1'b0; // [RULE20]
			BOD_FIELD_SOFT: brownout_detect_enable = soft_brownout_enable; // [RULE4] [RULE20]
			BOD_FIELD_NOSLEEP: brownout_detect_enable = !core_sleeping; // [RULE20]
			BOD_FIELD_ALWAYS: brownout_detect_enable = 1'b1; // [RULE20]
		endcase
	end

	assign brownout_active = brownout_trip && brownout_detect_enable;

	rcc_pin_filter u_pin_filter (
		.ref_clk(ref_clk),
		.srst(srst),
		.enable(ext_reset_pin_enable), // [RULE18]
		.pin_n(ext_reset_pin_n_in),
		.reset_req(pin_reset)
	);

	// the pin is input-only here; internal resets never pull it low
	assign ext_reset_pin_n_out = 1'b1; // [RULE17]
	assign ext_reset_pin_n_oe_n = 1'b1; // [RULE17]
	assign ext_reset_pin_pullup_en = ext_reset_pin_enable; // [RULE16]
	assign pin_digital_in = pin_sample;

	// source events on the asserting edge of power-on, brown-out and pin; the single-cycle sources count in every cycle they are high
	assign por_evt = supply_good && !supply_good_q; // [RULE19]
	assign bor_evt = brownout_active && !brownout_q;
	assign pin_evt = pin_reset && !pin_reset_q;
	assign wdt_evt = watchdog_timeout;
	assign instr_evt = reset_instr;
	assign stkf_evt = stack_full;
	assign stku_evt = stack_underflow;
	assign any_reset_evt = por_evt || bor_evt || pin_evt || wdt_evt || instr_evt || stkf_evt || stku_evt; // [RULE1]

	// power-on rise and single-cycle sources are stretched; level sources hold by themselves
	assign stretch_bus.load = por_evt || wdt_evt || instr_evt || stkf_evt || stku_evt; // [RULE19]

	rcc_reset_stretch u_stretch (
		.ref_clk(ref_clk),
		.srst(srst),
		.req(stretch_bus)
	);

	// por_evt bridges the cycle between supply rise and stretcher load, so reset never drops early
	assign sys_reset = srst || !supply_good || por_evt || brownout_active || pin_reset || stretch_bus.active; // [RULE21] [RULE15]

	assign ctrl_wr = reg_wr && (reg_addr == REG_CTRL_ADDR);

	// flag next state: software first, hardware events after so they win
	always_comb begin
		next_irq_priority_levels_on = irq_priority_levels_on;
		next_soft_brownout_enable = soft_brownout_enable;
		next_reset_instr_flag_n = reset_instr_flag_n;
		next_watchdog_timeout_flag_n = watchdog_timeout_flag_n;
		next_powerdown_flag_n = powerdown_flag_n;
		next_poweron_flag_n = poweron_flag_n;
		next_brownout_flag_n = brownout_flag_n;
		next_last_cause = last_cause;
		if (ctrl_wr) begin
			next_irq_priority_levels_on = reg_wdata[BIT_PRIO_LEVELS]; // [RULE3]
			if (soft_mode) begin
				next_soft_brownout_enable = reg_wdata[BIT_SOFT_BOD]; // [RULE4]
			end
			next_reset_instr_flag_n = reg_wdata[BIT_INSTR_N]; // [RULE7]
			next_poweron_flag_n = reg_wdata[BIT_POR]; // [RULE10]
			next_brownout_flag_n = reg_wdata[BIT_BROWN_N]; // [RULE11]
		end
		if (watchdog_clear_instr) begin
			next_watchdog_timeout_flag_n = 1'b1; // [RULE8]
			next_powerdown_flag_n = 1'b1; // [RULE9]
		end
		if (sleep_instr) begin
			next_watchdog_timeout_flag_n = 1'b1; // [RULE8]
			next_powerdown_flag_n = 1'b0; // [RULE9]
		end
		if (any_reset_evt) begin
			next_irq_priority_levels_on = RST_PRIO_LEVELS; // [RULE3]
		end
		if (stkf_evt) begin
			next_last_cause = CAUSE_STACK_FULL;
		end
		if (stku_evt) begin
			next_last_cause = CAUSE_STACK_UNDER;
		end
		if (instr_evt) begin
			next_reset_instr_flag_n = 1'b0; // [RULE7]
			next_last_cause = CAUSE_INSTR;
		end
		if (wdt_evt) begin
			next_watchdog_timeout_flag_n = 1'b0; // [RULE8]
			next_last_cause = CAUSE_WATCHDOG;
		end
		if (pin_evt) begin
			next_last_cause = core_power_managed ? CAUSE_PIN_PM : CAUSE_PIN_RUN;
		end
		// brown-out and power-on reload the power-up values; the power-on flag is reloaded only on power-on
		if (bor_evt || por_evt) begin
			next_soft_brownout_enable = soft_mode; // [RULE5] [RULE14]
			next_reset_instr_flag_n = RST_INSTR_N; // [RULE7] [RULE14]
			next_watchdog_timeout_flag_n = RST_WDOG_N; // [RULE8] [RULE14]
			next_powerdown_flag_n = RST_PWRDN_N; // [RULE9] [RULE14]
			next_brownout_flag_n = RST_BROWN_N; // [RULE11]
			next_last_cause = CAUSE_BROWNOUT;
		end
		if (por_evt) begin
			next_poweron_flag_n = RST_POR; // [RULE10]
			next_last_cause = CAUSE_POWER_ON;
		end
	end

	// control view: bit 5 unimplemented, bit 6 reads 0 outside software mode
	assign ctrl_view = {irq_priority_levels_on, soft_brownout_enable && soft_mode, 1'b0, // [RULE4] [RULE6]
		reset_instr_flag_n, watchdog_timeout_flag_n, powerdown_flag_n, poweron_flag_n, brownout_flag_n}; // [RULE2]

	// read data stands only in the cycle after the strobe
	always_comb begin
		next_reg_rdata = 8'h00;
		if (reg_rd) begin
			unique case (reg_addr)
				REG_CTRL_ADDR: next_reg_rdata = ctrl_view;
				REG_CAUSE_ADDR: next_reg_rdata = {4'h0, last_cause};
				default: next_reg_rdata = 8'h00;
			endcase
		end
	end

	// srst stands for a cold start: all flags take power-on values
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			irq_priority_levels_on <= RST_PRIO_LEVELS;
			soft_brownout_enable <= soft_mode; // [RULE5]
			reset_instr_flag_n <= RST_INSTR_N;
			watchdog_timeout_flag_n <= RST_WDOG_N;
			powerdown_flag_n <= RST_PWRDN_N;
			poweron_flag_n <= RST_POR;
			brownout_flag_n <= RST_BROWN_N;
			last_cause <= CAUSE_POWER_ON;
		end else begin
			irq_priority_levels_on <= next_irq_priority_levels_on;
			soft_brownout_enable <= next_soft_brownout_enable;
			reset_instr_flag_n <= next_reset_instr_flag_n;
			watchdog_timeout_flag_n <= next_watchdog_timeout_flag_n;
			powerdown_flag_n <= next_powerdown_flag_n;
			poweron_flag_n <= next_poweron_flag_n;
			brownout_flag_n <= next_brownout_flag_n;
			last_cause <= next_last_cause;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			reg_rdata <= 8'h00;
		end else begin
			reg_rdata <= next_reg_rdata;
		end
	end

	// edge detectors and the digital view of the pin
	always_comb begin
		next_supply_good_q = supply_good;
		next_brownout_q = brownout_active;
		next_pin_reset_q = pin_reset;
		next_pin_sample = ext_reset_pin_n_in; // [RULE18]
	end

	// supply_good_q cleared by srst, so every cold start shows a power-on event
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			supply_good_q <= 1'b0;
			brownout_q <= 1'b0;
			pin_reset_q <= 1'b0;
			pin_sample <= 1'b1;
		end else begin
			supply_good_q <= next_supply_good_q;
			brownout_q <= next_brownout_q;
			pin_reset_q <= next_pin_reset_q;
			pin_sample <= next_pin_sample;
		end
	end
endmodule : rcc_reset_cause

//--- verification/rcc_pin_model.sv
// Far-side model of the external reset pin: board driver plus pin pull-up.
// Assumes an active-low output enable from the design.
`timescale 1ns/1ps
module rcc_pin_model (
	input wire logic ref_clk,
	input wire logic hold_low,
	input wire logic pullup_en,
	input wire logic oe_n,
	input wire logic out_v,
	output logic pin
);
	logic noise = 1'b0;
	always @(posedge ref_clk) begin
		noise <= ~noise;
	end
	// floating pin without pull-up: changing level, never a stale one
	always_comb begin
		if (!oe_n)
			pin = out_v;
		else if (hold_low)
			pin = 1'b0;
		else if (pullup_en)
			pin = 1'b1;
		else
			pin = noise;
	end
endmodule : rcc_pin_model

//--- verification/rcc_reset_cause_checker.sv
// Port checker for the reset cause tracker.
// Bound onto rcc_reset_cause; single ref_clk domain.
`timescale 1ns/1ps
module rcc_reset_cause_checker
	import rcc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic [7:0] config_word_low2,
	input wire logic ext_reset_pin_enable,
	input wire logic ext_reset_pin_n_in,
	input wire logic ext_reset_pin_n_oe_n,
	input wire logic ext_reset_pin_pullup_en,
	input wire logic supply_good,
	input wire logic brownout_trip,
	input wire logic core_sleeping,
	input wire logic watchdog_timeout,
	input wire logic reset_instr,
	input wire logic sys_reset,
	input wire logic brownout_detect_enable,
	input wire rcc_pkg::rcc_cause_t last_cause
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (srst);
	logic up, next_up;
	logic [4:0] lows, next_lows;
	logic [1:0] fld;
	assign fld = config_word_low2[2:1];
	always_comb begin
		next_up = !srst;
		next_lows = 5'h00;
		if (!srst && ext_reset_pin_enable && !ext_reset_pin_n_in)
			next_lows = (lows == 5'h1F) ? lows : lows + 5'h01;
	end
	always_ff @(posedge ref_clk) begin
		up <= next_up;
		lows <= next_lows;
	end
	// first cycle out of reset fires a power-on event, so it is excluded
	sequence calm;
		up && supply_good && $stable(supply_good) && !brownout_trip && lows == 5'h00;
	endsequence
	sequence held_ten;
		sys_reset [*8] ##1 sys_reset ##1 sys_reset;
	endsequence
	a_pin_never_driven: assert property (ext_reset_pin_n_oe_n) else $error("pin driven");
	a_pullup_follows_mode: assert property (ext_reset_pin_pullup_en == ext_reset_pin_enable)
		else $error("pull-up wrong");
	a_unused_bit_zero: assert property (reg_rd |=> !reg_rdata[5]) else $error("bit 5 set");
	a_pulse_holds_reset: assert property (reset_instr ##0 calm |=> held_ten) else $error("hold short");
	a_watchdog_cause: assert property (watchdog_timeout ##0 calm |=> last_cause == CAUSE_WATCHDOG)
		else $error("watchdog cause");
	a_supply_low_reset: assert property (!supply_good |-> sys_reset) else $error("no reset");
	a_power_on_cause: assert property (up && $rose(supply_good) |=> last_cause == CAUSE_POWER_ON)
		else $error("power-on cause");
	a_bod_field_map: assert property (fld != BOD_FIELD_SOFT |->
		brownout_detect_enable == (fld == BOD_FIELD_ALWAYS || (fld == BOD_FIELD_NOSLEEP && !core_sleeping)))
		else $error("detect enable");
	a_pin_low_reset: assert property (lows > 5'h13 |-> sys_reset) else $error("pin ignored");
endmodule : rcc_reset_cause_checker

//--- verification/rcc_reset_cause_tb.sv
// Self-checking bench for the reset cause tracker, pin model on the far side.
// Assumes 10 MHz ref_clk and a cold start through srst.
`timescale 1ns/1ps
module rcc_reset_cause_tb;
	import rcc_pkg::*;
	logic ref_clk = 1'b0;
	logic srst = 1'b1;
	logic [1:0] reg_addr = 2'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic [7:0] config_word_low2 = 8'h02;
	logic [7:0] reg_rdata;
	logic reg_wr = 1'h0, reg_rd = 1'h0, ext_reset_pin_enable = 1'h1, hold_low = 1'h0;
	logic supply_good = 1'h1, brownout_trip = 1'h0;
	logic core_sleeping = 1'h0, core_power_managed = 1'h0, watchdog_timeout = 1'h0, watchdog_clear_instr = 1'h0;
	logic sleep_instr = 1'h0, reset_instr = 1'h0, stack_full = 1'h0, stack_underflow = 1'h0;
	logic ext_reset_pin_n_in, ext_reset_pin_n_out, ext_reset_pin_n_oe_n, ext_reset_pin_pullup_en;
	logic pin_digital_in, sys_reset, brownout_detect_enable, irq_priority_levels_on;
	rcc_cause_t last_cause;
	logic [7:0] ex [4] = '{8'h4F, 8'h5F, 8'h5F, 8'h57};
	logic [3:0] ca [4] = '{4'h6, 4'h7, 4'h8, 4'h4};
	int bad_count = 0;
	int cmp_count = 0;
	always #50 ref_clk = ~ref_clk;
	rcc_reset_cause uut (.ref_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .config_word_low2,
		.ext_reset_pin_enable, .ext_reset_pin_n_in, .ext_reset_pin_n_out, .ext_reset_pin_n_oe_n,
		.ext_reset_pin_pullup_en, .pin_digital_in, .supply_good, .brownout_trip, .core_sleeping,
		.core_power_managed, .watchdog_timeout, .watchdog_clear_instr, .sleep_instr, .reset_instr,
		.stack_full, .stack_underflow, .sys_reset, .brownout_detect_enable, .irq_priority_levels_on, .last_cause);
	rcc_pin_model pin_i (.ref_clk, .hold_low, .pullup_en(ext_reset_pin_pullup_en), .oe_n(ext_reset_pin_n_oe_n),
		.out_v(ext_reset_pin_n_out), .pin(ext_reset_pin_n_in));
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : report_and_stop
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rdc(input logic [1:0] a, input logic [7:0] exp, input string nm);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(negedge ref_clk);
		chk(nm, reg_rdata, exp);
	endtask : rdc
	task automatic pulse(input int k);
		@(posedge ref_clk);
		case (k)
			0: reset_instr <= 1'b1;
			1: stack_full <= 1'b1;
			2: stack_underflow <= 1'b1;
			3: watchdog_timeout <= 1'b1;
			4: sleep_instr <= 1'b1;
			default: watchdog_clear_instr <= 1'b1;
		endcase
		@(posedge ref_clk);
		{reset_instr, stack_full, stack_underflow, watchdog_timeout, sleep_instr, watchdog_clear_instr} <= 6'h00;
	endtask : pulse
	task automatic wait_idle;
		int n;
		n = 0;
		repeat (2) @(negedge ref_clk);
		while (sys_reset !== 1'b0) begin
			@(negedge ref_clk);
			n++;
			if (n > 60) begin
				bad_count++;
				$display("ERROR sys_reset expected 0 seen 1");
				report_and_stop;
			end
		end
	endtask : wait_idle
	task automatic quiet(input int n, input string nm);
		int hits;
		hits = 0;
		repeat (n) begin
			@(negedge ref_clk);
			hits += int'(sys_reset === 1'b1);
		end
		chk(nm, 8'(hits), 8'h00);
	endtask : quiet
	task automatic t_reset_values;
		rdc(2'h0, 8'h5C, "ctrl");
		@(negedge ref_clk);
		chk("rdata idle", reg_rdata, 8'h00);
		chk("pin drive", {6'h00, ext_reset_pin_n_out, ext_reset_pin_n_oe_n}, 8'h03);
		wr(2'h1, 8'hFF);
		wr(2'h3, 8'hFF);
		rdc(2'h1, 8'h01, "cause");
		rdc(2'h2, 8'h00, "unmapped");
		wr(2'h0, 8'hFF);
		rdc(2'h0, 8'hDF, "ctrl set");
		chk("prio", {7'h00, irq_priority_levels_on}, 8'h01);
		wr(2'h0, 8'h00);
		rdc(2'h0, 8'h0C, "ctrl clr");
		chk("bod soft", {7'h00, brownout_detect_enable}, 8'h00);
		$display("reset values done");
	endtask : t_reset_values
	task automatic t_event(input int k, input logic [7:0] exp, input logic [3:0] cause);
		wr(2'h0, 8'hFF);
		pulse(k);
		wait_idle;
		rdc(2'h0, exp, "event ctrl");
		rdc(2'h1, {4'h0, cause}, "event cause");
		chk("prio off", {7'h00, irq_priority_levels_on}, 8'h00);
		$display("event %0d done", k);
	endtask : t_event
	task automatic t_sleep;
		pulse(4);
		rdc(2'h0, 8'h5B, "sleep");
		pulse(5);
		rdc(2'h0, 8'h5F, "wdt clear");
		$display("sleep done");
	endtask : t_sleep
	task automatic t_pin(input logic pm, input logic [7:0] cause);
		wr(2'h0, 8'hFF);
		core_power_managed <= pm;
		hold_low <= 1'b1;
		repeat (25) @(posedge ref_clk);
		hold_low <= 1'b0;
		wait_idle;
		rdc(2'h0, 8'h5F, "pin ctrl");
		rdc(2'h1, cause, "pin cause");
		hold_low <= 1'b1;
		quiet(10, "noise");
		ext_reset_pin_enable <= 1'b0;
		quiet(30, "pin off");
		chk("dig in", {7'h00, pin_digital_in}, 8'h00);
		@(posedge ref_clk);
		{hold_low, core_power_managed, ext_reset_pin_enable} <= 3'h1;
		$display("pin done");
	endtask : t_pin
	task automatic t_brownout;
		wr(2'h0, 8'hFF);
		brownout_trip <= 1'b1;
		repeat (2) @(posedge ref_clk);
		brownout_trip <= 1'b0;
		wait_idle;
		rdc(2'h0, 8'h5E, "brown ctrl");
		rdc(2'h1, 8'h05, "brown cause");
		wr(2'h0, 8'hBF);
		brownout_trip <= 1'b1;
		quiet(4, "brown off");
		for (int f = 0; f < 5; f++) begin
			@(posedge ref_clk);
			brownout_trip <= 1'b0;
			config_word_low2 <= {5'h00, ((f == 4) ? 2'h2 : 2'(f)), 1'h0};
			core_sleeping <= (f < 4);
			@(negedge ref_clk);
			chk("bod map", {7'h00, brownout_detect_enable}, 8'((f % 4) > 2 || f == 4 ? 1 : 0));
		end
		wr(2'h0, 8'hFF);
		rdc(2'h0, 8'h9F, "bit6 off");
		config_word_low2 <= 8'h02;
		core_sleeping <= 1'b0;
		$display("brown-out done");
	endtask : t_brownout
	task automatic t_power_on;
		wr(2'h0, 8'hFF);
		supply_good <= 1'b0;
		repeat (3) @(posedge ref_clk);
		supply_good <= 1'b1;
		wait_idle;
		rdc(2'h0, 8'h5C, "por ctrl");
		rdc(2'h1, 8'h01, "por cause");
		$display("power-on done");
	endtask : t_power_on
	initial begin
		repeat (20) @(posedge ref_clk);
		srst <= 1'b0;
		wait_idle;
		t_reset_values;
		for (int k = 0; k < 4; k++) begin
			t_event(k, ex[k], ca[k]);
		end
		t_sleep;
		t_pin(1'b0, 8'h02);
		t_pin(1'b1, 8'h03);
		t_brownout;
		t_power_on;
		report_and_stop;
	end
endmodule : rcc_reset_cause_tb
bind rcc_reset_cause rcc_reset_cause_checker chk_i (.ref_clk, .srst, .reg_rd, .reg_rdata, .config_word_low2,
	.ext_reset_pin_enable, .ext_reset_pin_n_in, .ext_reset_pin_n_oe_n, .ext_reset_pin_pullup_en, .supply_good,
	.brownout_trip, .core_sleeping, .watchdog_timeout, .reset_instr, .sys_reset, .brownout_detect_enable,
	.last_cause);
